// ===== outport_pkg.sv
`default_nettype none
package outport_pkg;
	// register addresses in i/o data memory
	localparam logic [7:0] ADDR_OUT_HIGH = 8'hD3;
	localparam logic [7:0] ADDR_OUT_LOW = 8'hD4;
	localparam logic [7:0] ADDR_TONE_CTRL = 8'hDD;
	localparam logic [7:0] ADDR_LINE_CTRL = 8'hE3;
	localparam logic [7:0] ADDR_SPKR_CTRL = 8'hE4;
	localparam logic [7:0] ADDR_SPECIAL_SEL = 8'hEA;
	// field positions
	localparam int TONE_FREQ_BIT = 0;
	localparam int INV_TONE_BIT = 2;
	localparam int TONE_SEL_BIT = 3;
	localparam int FLASH_BIT = 0;
	localparam int PAUSE_BIT = 1;
	localparam int LINE_KEEP_BIT = 2;
	localparam int SPKR_BIT = 3;
	localparam int LINE_KEEP_SEL_BIT = 2;
	localparam int SPKR_SEL_BIT = 3;
	// reset value shared by all nibbles
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	// tone timing: half period of the 4 kHz tone
	localparam int CLK_HZ = 20000000;
	localparam int TONE_HZ_FAST = 4000;
	localparam int HALF_CYCLES = CLK_HZ / (2 * TONE_HZ_FAST);
endpackage : outport_pkg
`default_nettype wire

// ===== output_port_special_mux.sv
// Contract
// [RQ1] terminals drive their register bits
// [RQ2] reset clears all eight output bits
// [RQ3] output registers read back stored values
// [RQ4] reset clears every special select bit
// [RQ5] software clears select for plain output
// [RQ6] tone_sel: tone on bit0, high on bit1
// [RQ7] inv_tone_sel: inverted tone likewise on terminal0
// [RQ8] select cleared with bit zero drives low
// [RQ9] tone 4 kHz, or 2 kHz with tone_freq_sel
// [RQ10] line_keep_sel: line_keep_bit or forced high
// [RQ11] spkr_sel: spkr_ctrl or forced high
// [RQ12] line register: keep bit, write-only triggers
// [RQ13] unused bits read zero, no storage
// [RQ14] software clears register bit before select
// [RQ15] low nibble and high nibble registers
// [RQ16] tone control bits 3,2,0; bit1 unused
// [RQ17] tone from divider, exact complements
`timescale 1ns/1ns
`default_nettype none
module output_port_special_mux #(
	parameter int HALF_CYCLES = outport_pkg::HALF_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_wdata,
	output logic [3:0] o_rdata,
	output logic [3:0] o_out_low_nibble,
	output logic [3:0] o_out_high_nibble,
	output logic o_pause_pulse,
	output logic o_flash_pulse
);

	typedef struct packed {
		logic [3:0] out_low;
		logic [3:0] out_high;
		logic tone_sel;
		logic inv_tone_sel;
		logic tone_freq_sel;
		logic line_keep_bit;
		logic spkr_ctrl;
		logic line_keep_sel;
		logic spkr_sel;
		logic [15:0] div_cnt;
		logic half_tog;
		logic tone;
		logic [3:0] pin_high;
		logic [3:0] rdata;
		logic pause_pulse;
		logic flash_pulse;
	} state_t;

	state_t cur;
	state_t next_cur;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_cur = cur;
		next_cur.pause_pulse = 1'h0;
		next_cur.flash_pulse = 1'h0;
		// register writes; unused bits are simply not stored
		if (i_wr) begin
			if (hit(i_addr, outport_pkg::ADDR_OUT_LOW)) next_cur.out_low = i_wdata; // see [RQ15]
			if (hit(i_addr, outport_pkg::ADDR_OUT_HIGH)) next_cur.out_high = i_wdata; // see [RQ15]
			if (hit(i_addr, outport_pkg::ADDR_TONE_CTRL)) begin
				next_cur.tone_sel = i_wdata[outport_pkg::TONE_SEL_BIT]; // see [RQ16]
				next_cur.inv_tone_sel = i_wdata[outport_pkg::INV_TONE_BIT];
				next_cur.tone_freq_sel = i_wdata[outport_pkg::TONE_FREQ_BIT];
			end
			if (hit(i_addr, outport_pkg::ADDR_LINE_CTRL)) begin
				next_cur.line_keep_bit = i_wdata[outport_pkg::LINE_KEEP_BIT]; // see [RQ12]
				next_cur.pause_pulse = i_wdata[outport_pkg::PAUSE_BIT];
				next_cur.flash_pulse = i_wdata[outport_pkg::FLASH_BIT];
			end
			if (hit(i_addr, outport_pkg::ADDR_SPKR_CTRL))
				next_cur.spkr_ctrl = i_wdata[outport_pkg::SPKR_BIT];
			if (hit(i_addr, outport_pkg::ADDR_SPECIAL_SEL)) begin
				next_cur.line_keep_sel = i_wdata[outport_pkg::LINE_KEEP_SEL_BIT];
				next_cur.spkr_sel = i_wdata[outport_pkg::SPKR_SEL_BIT];
			end
		end
		// read data registered one cycle after i_rd; unused bits zero
		next_cur.rdata = 4'h0; // see [RQ13]
		if (i_rd) begin
			if (hit(i_addr, outport_pkg::ADDR_OUT_LOW)) next_cur.rdata = cur.out_low; // see [RQ3]
			if (hit(i_addr, outport_pkg::ADDR_OUT_HIGH)) next_cur.rdata = cur.out_high; // see [RQ3]
			if (hit(i_addr, outport_pkg::ADDR_TONE_CTRL))
				next_cur.rdata = {cur.tone_sel, cur.inv_tone_sel, 1'h0, cur.tone_freq_sel};
			if (hit(i_addr, outport_pkg::ADDR_LINE_CTRL))
				next_cur.rdata = {1'h0, cur.line_keep_bit, 2'h0}; // see [RQ12]
			if (hit(i_addr, outport_pkg::ADDR_SPKR_CTRL))
				next_cur.rdata = {cur.spkr_ctrl, 3'h0};
			if (hit(i_addr, outport_pkg::ADDR_SPECIAL_SEL))
				next_cur.rdata = {cur.spkr_sel, cur.line_keep_sel, 2'h0};
		end
		// tone divider: 2 kHz toggles the tone every other half period
		// limitation: the 16-bit divider caps HALF_CYCLES at 65536
		if (cur.div_cnt >= 16'(HALF_CYCLES - 1)) begin
			next_cur.div_cnt = 16'h0000;
			next_cur.half_tog = ~cur.half_tog;
			if (!cur.tone_freq_sel || cur.half_tog) next_cur.tone = ~cur.tone; // see [RQ9]
		end else begin
			next_cur.div_cnt = cur.div_cnt + 16'h0001;
		end
		// terminal mux; register bit 1 forces high, bit 0 passes special source
		next_cur.pin_high[0] = cur.out_high[0] | (cur.inv_tone_sel & ~cur.tone); // see [RQ7]
		next_cur.pin_high[1] = cur.out_high[1] | (cur.tone_sel & cur.tone); // see [RQ6] [RQ8] [RQ17]
		next_cur.pin_high[2] = cur.out_high[2] | (cur.line_keep_sel & cur.line_keep_bit); // see [RQ10]
		next_cur.pin_high[3] = cur.out_high[3] | (cur.spkr_sel & cur.spkr_ctrl); // see [RQ11]
	end

	////////////////////////////////////////////////////////////////////
	// state register; reset makes every terminal a plain low output
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cur <= '0; // see [RQ2] [RQ4]
		end else begin
			cur <= next_cur;
		end
	end

	assign o_out_low_nibble = cur.out_low; // see [RQ1]
	assign o_out_high_nibble = cur.pin_high;
	assign o_rdata = cur.rdata;
	assign o_pause_pulse = cur.pause_pulse;
	assign o_flash_pulse = cur.flash_pulse;

	////////////////////////////////////////////////////////////////////
	// checks
	sequence wr_low_s;
		i_wr && i_addr == outport_pkg::ADDR_OUT_LOW;
	endsequence

	AST_LOW_DRIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ1]
		wr_low_s |=> o_out_low_nibble == $past(i_wdata))
		else $error("low nibble not driven");
	AST_RESET_LOW: assert property (@(posedge i_sys_clk) // see [RQ2]
		i_rst |=> o_out_low_nibble == 4'h0 && cur.out_high == 4'h0)
		else $error("outputs not cleared");
	AST_READBACK: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ3]
		(i_rd && !i_wr && i_addr == outport_pkg::ADDR_OUT_LOW) |=> o_rdata == o_out_low_nibble)
		else $error("readback wrong");
	AST_RESET_SEL: assert property (@(posedge i_sys_clk) // see [RQ4]
		i_rst |=> !cur.tone_sel && !cur.inv_tone_sel && !cur.line_keep_sel && !cur.spkr_sel)
		else $error("selects not cleared");
	AST_TONE_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ6]
		(cur.out_high[1] && cur.tone_sel) |=> o_out_high_nibble[1])
		else $error("terminal1 not high");
	AST_COMPLEMENT: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ17]
		(cur.tone_sel && cur.inv_tone_sel && cur.out_high[1:0] == 2'b00)
		|=> o_out_high_nibble[0] != o_out_high_nibble[1])
		else $error("tones not complements");
	AST_PLAIN_LOW: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ8]
		(!cur.out_high[1] && !cur.tone_sel) |=> !o_out_high_nibble[1])
		else $error("terminal1 not low");
	AST_LINE_KEEP: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ10]
		(cur.line_keep_sel && !cur.out_high[2]) |=> o_out_high_nibble[2] == $past(cur.line_keep_bit))
		else $error("line keep mismatch");
	AST_SPKR: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ11]
		(cur.spkr_sel && !cur.out_high[3]) |=> o_out_high_nibble[3] == $past(cur.spkr_ctrl))
		else $error("spkr mismatch");
	AST_TRIG_READ0: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ12]
		(i_rd && i_addr == outport_pkg::ADDR_LINE_CTRL) |=> o_rdata[1:0] == 2'b00)
		else $error("trigger bits read nonzero");
	AST_TONE_UNUSED: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ13] [RQ16]
		(i_rd && i_addr == outport_pkg::ADDR_TONE_CTRL) |=> !o_rdata[1])
		else $error("unused bit nonzero");
	AST_FAST_TONE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ9]
		(!cur.tone_freq_sel && !$past(cur.tone_freq_sel) && cur.div_cnt == 16'h0000 && $past(cur.div_cnt) != 16'h0000)
		|-> cur.tone != $past(cur.tone))
		else $error("4 kHz tone not toggling");

	////////////////////////////////////////////////////////////////////
	// special sources and the plain path of the upper group
	AST_HIGH_DRIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ1]
		(!cur.tone_sel && !cur.inv_tone_sel && !cur.line_keep_sel && !cur.spkr_sel)
		|=> o_out_high_nibble == $past(cur.out_high))
		else $error("high nibble not driven");
	AST_TRUE_TONE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ6]
		(cur.tone_sel && !cur.out_high[1]) |=> o_out_high_nibble[1] == $past(cur.tone))
		else $error("terminal1 not carrying tone");
	AST_INV_TONE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ7]
		(cur.inv_tone_sel && !cur.out_high[0]) |=> o_out_high_nibble[0] != $past(cur.tone))
		else $error("terminal0 not carrying inverted tone");
	AST_INV_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ7]
		(cur.out_high[0] && cur.inv_tone_sel) |=> o_out_high_nibble[0])
		else $error("terminal0 not high");
	AST_INV_LOW: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ8]
		(!cur.out_high[0] && !cur.inv_tone_sel) |=> !o_out_high_nibble[0])
		else $error("terminal0 not low");

	////////////////////////////////////////////////////////////////////
	// trigger pulses: one cycle per write, nothing stored behind them
	sequence wr_line_s;
		i_wr && i_addr == outport_pkg::ADDR_LINE_CTRL;
	endsequence

	AST_PULSE_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ12]
		wr_line_s |=> o_pause_pulse == $past(i_wdata[outport_pkg::PAUSE_BIT])
		&& o_flash_pulse == $past(i_wdata[outport_pkg::FLASH_BIT]))
		else $error("trigger pulse wrong");
	AST_PULSE_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ12]
		!(i_wr && i_addr == outport_pkg::ADDR_LINE_CTRL) |=> !o_pause_pulse && !o_flash_pulse)
		else $error("trigger pulse without write");

	////////////////////////////////////////////////////////////////////
	// read path: zero when idle, unused positions never stored
	AST_READ_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ13]
		!i_rd |=> o_rdata == 4'h0)
		else $error("read data not idle");
	AST_SEL_UNUSED: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ13]
		(i_rd && i_addr == outport_pkg::ADDR_SPECIAL_SEL) |=> o_rdata[1:0] == 2'h0)
		else $error("select unused bits nonzero");
	AST_SPKR_UNUSED: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RQ13]
		(i_rd && i_addr == outport_pkg::ADDR_SPKR_CTRL) |=> o_rdata[2:0] == 3'h0)
		else $error("speaker unused bits nonzero");
endmodule : output_port_special_mux
`default_nettype wire

// ===== cpu_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// cpu side of the data memory bus, one access at a time
module cpu_bus_model (
	input wire logic i_sys_clk,
	input wire logic [3:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [3:0] o_wdata
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'h0;
		o_rd = 1'h0;
		o_wdata = 4'h0;
	end
	// data inverted once released, so stale data never looks valid
	task wr(input logic [7:0] a, input logic [3:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wr <= 1'h1;
		o_wdata <= d;
		@(posedge i_sys_clk);
		o_wr <= 1'h0;
		o_wdata <= ~d;
	endtask : wr
	// read data is registered: taken just after the accepting edge
	task rd(input logic [7:0] a, output logic [3:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'h1;
		@(posedge i_sys_clk);
		o_rd <= 1'h0;
		#1 d = i_rdata;
	endtask : rd
endmodule : cpu_bus_model
`default_nettype wire

// ===== output_port_special_mux_test.sv
`timescale 1ns/1ns
`default_nettype none
module output_port_special_mux_test;
	localparam int HALF = 4; // short tone half period keeps the run brief
	logic i_sys_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [7:0] addr;
	logic wr, rd, pause, flash;
	logic [3:0] wdata, rdata, lo, hi, v;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	// 50 ns clock
	always #25 i_sys_clk = ~i_sys_clk;
	cpu_bus_model cpu (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
		.o_rd(rd), .o_wdata(wdata));
	output_port_special_mux #(.HALF_CYCLES(HALF)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
		.o_out_low_nibble(lo), .o_out_high_nibble(hi), .o_pause_pulse(pause),
		.o_flash_pulse(flash));
	////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task rchk(input string nm, input logic [7:0] a, input logic [3:0] e);
		cpu.rd(a, v);
		chk(nm, {4'h0, e}, {4'h0, v});
	endtask : rchk
	// high group is one edge behind the write
	task settle;
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask : settle
	// wait for a tone edge, then count one full half period
	// looks 1 ns after each edge, never in the time step that launches the pin
	task meas;
		logic p;
		#1;
		p = hi[1];
		for (n = 0; hi[1] === p && n < 40; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
		p = hi[1];
		for (n = 0; hi[1] === p && n < 40; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
	endtask : meas
	task test_done;
		if (error_cnt == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////
	task t_plain;
		chk("reset out", 8'h00, {lo, hi});
		cpu.wr(outport_pkg::ADDR_OUT_LOW, 4'hA);
		#1 chk("low", 8'h0A, {4'h0, lo});
		cpu.wr(outport_pkg::ADDR_OUT_HIGH, 4'h5);
		settle;
		chk("high", 8'h05, {4'h0, hi});
		rchk("low rb", outport_pkg::ADDR_OUT_LOW, 4'hA);
		rchk("high rb", outport_pkg::ADDR_OUT_HIGH, 4'h5);
		cpu.wr(outport_pkg::ADDR_OUT_HIGH, 4'h0);
	endtask : t_plain
	task t_regs;
		cpu.wr(outport_pkg::ADDR_LINE_CTRL, 4'hF);
		#1 chk("pulse", 8'h03, {6'h0, pause, flash});
		@(posedge i_sys_clk);
		#1 chk("pulse end", 8'h00, {6'h0, pause, flash});
		rchk("line rb", outport_pkg::ADDR_LINE_CTRL, 4'h4);
		cpu.wr(outport_pkg::ADDR_SPKR_CTRL, 4'hF);
		rchk("spkr rb", outport_pkg::ADDR_SPKR_CTRL, 4'h8);
		cpu.wr(outport_pkg::ADDR_SPECIAL_SEL, 4'hF);
		rchk("sel rb", outport_pkg::ADDR_SPECIAL_SEL, 4'hC);
		cpu.wr(8'h00, 4'hF);
		rchk("unmapped", 8'h00, 4'h0);
		chk("keep spkr", 8'h0C, {4'h0, hi});
		cpu.wr(outport_pkg::ADDR_LINE_CTRL, 4'h0);
		cpu.wr(outport_pkg::ADDR_SPKR_CTRL, 4'h0);
		settle;
		chk("keep spkr off", 8'h00, {4'h0, hi});
		cpu.wr(outport_pkg::ADDR_OUT_HIGH, 4'hC);
		settle;
		chk("forced high", 8'h0C, {4'h0, hi});
		cpu.wr(outport_pkg::ADDR_SPECIAL_SEL, 4'h0);
		cpu.wr(outport_pkg::ADDR_OUT_HIGH, 4'h0);
	endtask : t_regs
	task t_tone;
		cpu.wr(outport_pkg::ADDR_TONE_CTRL, 4'hF);
		rchk("tone rb", outport_pkg::ADDR_TONE_CTRL, 4'hD);
		meas;
		meas;
		chk("2k half", 8'(2 * HALF), 8'(n));
		cpu.wr(outport_pkg::ADDR_TONE_CTRL, 4'hC);
		meas;
		meas;
		chk("4k half", 8'(HALF), 8'(n));
		#1 chk("inverse", {7'h0, ~hi[1]}, {7'h0, hi[0]});
		cpu.wr(outport_pkg::ADDR_OUT_HIGH, 4'h3);
		settle;
		repeat (3) begin
			chk("steady", 8'h03, {4'h0, hi});
			repeat (HALF) @(posedge i_sys_clk);
			#1;
		end
		cpu.wr(outport_pkg::ADDR_OUT_HIGH, 4'h0);
		cpu.wr(outport_pkg::ADDR_TONE_CTRL, 4'h0);
		settle;
		chk("tone off", 8'h00, {4'h0, hi});
	endtask : t_tone
	// mid-run reset with outputs and selects set; register bits cleared first
	task t_reset;
		cpu.wr(outport_pkg::ADDR_OUT_LOW, 4'hF);
		cpu.wr(outport_pkg::ADDR_TONE_CTRL, 4'hD);
		cpu.wr(outport_pkg::ADDR_SPECIAL_SEL, 4'hC);
		@(posedge i_sys_clk);
		i_rst <= 1'h1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		#1 chk("rst out", 8'h00, {lo, hi});
		rchk("rst tone", outport_pkg::ADDR_TONE_CTRL, 4'h0);
		rchk("rst sel", outport_pkg::ADDR_SPECIAL_SEL, 4'h0);
	endtask : t_reset
	////////////////////////////////////////////////////////////
	// cut a hang short
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			test_done;
		end
	end
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		#1;
		t_plain;
		t_regs;
		t_tone;
		t_reset;
		test_done;
	end
endmodule : output_port_special_mux_test
`default_nettype wire
